// ### src/sw_out_pkg.sv
package sw_out_pkg;

    // Clock and time bases
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned EXT_SHORT_MS = 10;
    localparam int unsigned EXT_MID_MS = 100;
    localparam int unsigned EXT_LONG_MS = 1000;
    localparam int unsigned EXT_SHORT_CYC = CLK_HZ / 1000 * EXT_SHORT_MS;
    localparam int unsigned EXT_MID_CYC = CLK_HZ / 1000 * EXT_MID_MS;
    localparam int unsigned EXT_LONG_CYC = CLK_HZ / 1000 * EXT_LONG_MS;
    localparam int unsigned BLINK_HALF_MS = 125;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int TMR_W = 26;

    // Front-end pin positions in the synchroniser vector
    localparam int NPIN = 5;
    localparam int PIN_NEAR = 0;
    localparam int PIN_RATED = 1;
    localparam int PIN_ASSURED = 2;
    localparam int PIN_TEMP_HI = 3;
    localparam int PIN_TEMP_OVER = 4;

    // Input process data layout
    localparam int PD_W = 8;
    localparam int PD_SWITCH_BIT = 0;
    localparam int PD_DIAG_BIT = 1;

    typedef enum logic [1:0] {
        MODE_RATED,
        MODE_NEAR,
        MODE_WINDOW
    } sp_mode_t;

    typedef enum logic [2:0] {
        EXT_OFF,
        EXT_AUTO,
        EXT_10MS,
        EXT_100MS,
        EXT_1S
    } ext_sel_t;

    typedef enum logic [1:0] {
        TEMP_NORMAL,
        TEMP_CRITICAL,
        TEMP_OVER
    } temp_lvl_t;

    // Factory defaults
    localparam sp_mode_t DEF_MODE = MODE_RATED;
    localparam logic DEF_NC = 1'h0;
    localparam ext_sel_t DEF_EXT = EXT_OFF;
    localparam logic DEF_ALARM_LOW = 1'h0;
    localparam logic DEF_DS_LOCK = 1'h0;
    localparam logic [15:0] DEF_MCYC_US = 16'h0000;

    // Communication characteristics
    localparam logic [15:0] MIN_CYCLE_US = 16'h08fc;
    localparam logic [7:0] VERSION_ID = 8'h11;

endpackage

// ### src/pulse_stretch.sv
`timescale 1ns/1ps
module pulse_stretch (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Level and setting
    input wire logic en,
    input wire logic [sw_out_pkg::TMR_W-1:0] dur,
    input wire logic level_in,
    // Stretched level
    output logic level_out
);

    typedef struct packed {
        logic prev;
        logic [sw_out_pkg::TMR_W-1:0] cnt;
    } st_t;

    st_t q;
    st_t n;

    always_comb begin
        n = q;
        n.prev = level_in;
        if (!en) begin
            n.cnt = '0;
        end else if (level_in && !q.prev) begin
            // Restart on every new high level
            n.cnt = (dur == '0) ? '0 : dur - sw_out_pkg::TMR_W'(1);
        end else if (q.cnt != '0) begin
            n.cnt = q.cnt - sw_out_pkg::TMR_W'(1);
        end
    end

    // High level held while the timer runs
    assign level_out = level_in | (en & (q.cnt != '0));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= n;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence rise_s;
        ce && en && level_in && !q.prev && dur != '0;
    endsequence

    // Switching extension off mid-stretch releases the level at once
    sequence running_s;
        en && q.cnt != '0;
    endsequence

    timer_load_a: assert property (
        rise_s |=> q.cnt == $past(dur) - 1)
        else $error("Stretch timer not loaded on rising level");

    level_hold_a: assert property (
        running_s |-> level_out)
        else $error("Stretched level dropped while timer runs");

    off_direct_a: assert property (
        !en |-> level_out == level_in)
        else $error("Level stretched although extension is off");

endmodule

// ### src/switching_output_conditioner.sv
// Behaviour
// - Polarity setting inverts the switching signal: open active high.
// - Active-high with extension holds the high level the minimum time.
// - Active-low shows detection low; high level still stretched.
// - Extension off: output and process bit follow detection directly.
// - Automatic extension stretches to the master cycle time in use.
// - Fixed stretch choices of 10 ms, 100 ms and 1 s.
// - Raised stability alarm flashes the LED and sets the diagnosis bit.
// - Alarm bit polarity is configurable apart from output polarity.
// - Rated mode: alarm for object between assured and rated distance.
// - Window mode: alarm when object nearer than the window.
// - Alarm stays inactive unless rated setpoint or window mode.
// - Storage lock stops forwarding parameter changes to the master.
// - Factory restore returns every parameter except the master cycle time to its default.
// - Switching status reads active while an object is detected.
// - Diagnosis status shows normal or stability alarm triggered.
// - Temperature shown as normal, critical high or overtemperature.
// - Switching and diagnosis channel bits published as input data.
// - Min cycle time, master cycle time, version id readable.
// - Switching signal at bit 0, alarm at bit 1 of one byte.
// - Modes: rated setpoint, near setpoint, or window between them.
`timescale 1ns/1ps
module switching_output_conditioner #(
    parameter logic [sw_out_pkg::TMR_W-1:0] CYC_10MS =
        sw_out_pkg::TMR_W'(sw_out_pkg::EXT_SHORT_CYC),
    parameter logic [sw_out_pkg::TMR_W-1:0] CYC_100MS =
        sw_out_pkg::TMR_W'(sw_out_pkg::EXT_MID_CYC),
    parameter logic [sw_out_pkg::TMR_W-1:0] CYC_1S =
        sw_out_pkg::TMR_W'(sw_out_pkg::EXT_LONG_CYC),
    parameter logic [sw_out_pkg::TMR_W-1:0] BLINK_CYC =
        sw_out_pkg::TMR_W'(sw_out_pkg::BLINK_HALF_CYC)
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Sensing front end, asynchronous
    input wire logic near_hit,
    input wire logic rated_hit,
    input wire logic assured_hit,
    input wire logic temp_high,
    input wire logic temp_over,
    // Parameter writes from the link
    input wire logic param_wr,
    input wire logic [1:0] wr_mode,
    input wire logic wr_nc,
    input wire logic [2:0] wr_ext,
    input wire logic wr_alarm_low,
    input wire logic wr_ds_lock,
    input wire logic factory_restore,
    // Master cycle time
    input wire logic master_cycle_wr,
    input wire logic [15:0] master_cycle_us,
    // Data storage forwarding
    input wire logic ds_ack,
    output logic ds_upload_req,
    // Switching output and indicator
    output logic switch_out,
    output logic led_flash,
    // Process data and status
    output logic [sw_out_pkg::PD_W-1:0] pd_in,
    output logic switch_status,
    output logic diag_status,
    output logic [1:0] temp_state,
    // Communication characteristics
    output logic [15:0] min_cycle_us,
    output logic [15:0] master_cycle_time,
    output logic [7:0] version_id,
    // Current parameters
    output logic [1:0] cur_mode,
    output logic cur_nc,
    output logic [2:0] cur_ext,
    output logic cur_alarm_low,
    output logic cur_ds_lock
);

    typedef struct packed {
        logic [sw_out_pkg::NPIN-1:0] s1;
        logic [sw_out_pkg::NPIN-1:0] s2;
        logic [sw_out_pkg::NPIN-1:0] s3;
        logic [sw_out_pkg::NPIN-1:0] pins;
        sw_out_pkg::sp_mode_t mode;
        logic nc;
        sw_out_pkg::ext_sel_t ext;
        logic alarm_low;
        logic ds_lock;
        logic [15:0] mcyc;
        logic ds_pend;
        logic det;
        logic alarm;
        logic [sw_out_pkg::PD_W-1:0] pd;
        sw_out_pkg::temp_lvl_t temp;
        logic [sw_out_pkg::TMR_W-1:0] blink_cnt;
        logic blink;
    } state_t;

    localparam state_t RST_STATE = '{
        mode: sw_out_pkg::DEF_MODE,
        nc: sw_out_pkg::DEF_NC,
        ext: sw_out_pkg::DEF_EXT,
        alarm_low: sw_out_pkg::DEF_ALARM_LOW,
        ds_lock: sw_out_pkg::DEF_DS_LOCK,
        mcyc: sw_out_pkg::DEF_MCYC_US,
        temp: sw_out_pkg::TEMP_NORMAL,
        default: '0
    };

    state_t q;
    state_t n;

    logic [sw_out_pkg::NPIN-1:0] pins_raw;
    logic det_raw;
    logic alarm_raw;
    logic level;
    logic stretched;
    logic ext_on;
    logic [sw_out_pkg::TMR_W-1:0] dur;

    function automatic logic detect_of(input sw_out_pkg::sp_mode_t m,
                                       input logic [4:0] p);
        // Window covers objects between the two distances
        case (m)
            sw_out_pkg::MODE_NEAR: detect_of = p[sw_out_pkg::PIN_NEAR];
            sw_out_pkg::MODE_WINDOW: detect_of = p[sw_out_pkg::PIN_RATED] &
                ~p[sw_out_pkg::PIN_NEAR];
            default: detect_of = p[sw_out_pkg::PIN_RATED];
        endcase
    endfunction

    function automatic logic alarm_of(input sw_out_pkg::sp_mode_t m,
                                      input logic [4:0] p);
        case (m)
            // Marginal zone where drift can lose the object
            sw_out_pkg::MODE_RATED: alarm_of = p[sw_out_pkg::PIN_RATED] &
                ~p[sw_out_pkg::PIN_ASSURED];
            // Object below the window
            sw_out_pkg::MODE_WINDOW: alarm_of = p[sw_out_pkg::PIN_NEAR];
            // No alarm in near setpoint mode
            default: alarm_of = 1'h0;
        endcase
    endfunction

    function automatic logic [sw_out_pkg::TMR_W-1:0] dur_of(
        input sw_out_pkg::ext_sel_t e, input logic [15:0] us);
        case (e)
            // Master cycle converted to clock cycles
            sw_out_pkg::EXT_AUTO: dur_of = sw_out_pkg::TMR_W'(us *
                sw_out_pkg::CYC_PER_US);
            sw_out_pkg::EXT_10MS: dur_of = CYC_10MS;
            sw_out_pkg::EXT_100MS: dur_of = CYC_100MS;
            sw_out_pkg::EXT_1S: dur_of = CYC_1S;
            default: dur_of = '0;
        endcase
    endfunction

    assign pins_raw = {temp_over, temp_high, assured_hit, rated_hit, near_hit};
    assign det_raw = detect_of(q.mode, q.pins);
    assign alarm_raw = alarm_of(q.mode, q.pins);
    // Normally-closed turns detection into a low level
    assign level = det_raw ^ q.nc;
    assign ext_on = q.ext != sw_out_pkg::EXT_OFF;
    assign dur = dur_of(q.ext, q.mcyc);

    pulse_stretch stretch_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .en(ext_on),
        .dur(dur),
        .level_in(level),
        .level_out(stretched)
    );

    always_comb begin
        n = q;
        // Three stages; a rise counts once stages two and three agree, a fall as soon as they differ
        n.s1 = pins_raw;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.pins = (q.s2 & q.s3) | (q.pins & ~(q.s2 ^ q.s3));

        n.det = det_raw;
        n.alarm = alarm_raw;
        n.pd = '0;
        n.pd[sw_out_pkg::PD_SWITCH_BIT] = stretched;
        // Alarm polarity set apart from output polarity
        n.pd[sw_out_pkg::PD_DIAG_BIT] = alarm_raw ^ q.alarm_low;

        // Overtemperature outranks the critical warning
        if (q.pins[sw_out_pkg::PIN_TEMP_OVER]) begin
            n.temp = sw_out_pkg::TEMP_OVER;
        end else if (q.pins[sw_out_pkg::PIN_TEMP_HI]) begin
            n.temp = sw_out_pkg::TEMP_CRITICAL;
        end else begin
            n.temp = sw_out_pkg::TEMP_NORMAL;
        end

        // LED flashes while the alarm stands
        if (!q.alarm) begin
            n.blink_cnt = '0;
            n.blink = 1'h0;
        end else if (q.blink_cnt >= BLINK_CYC - sw_out_pkg::TMR_W'(1)) begin
            n.blink_cnt = '0;
            n.blink = ~q.blink;
        end else begin
            n.blink_cnt = q.blink_cnt + sw_out_pkg::TMR_W'(1);
        end

        if (master_cycle_wr) begin
            n.mcyc = master_cycle_us;
        end

        // Restore outranks a write in the same cycle
        if (factory_restore) begin
            n.mode = sw_out_pkg::DEF_MODE;
            n.nc = sw_out_pkg::DEF_NC;
            n.ext = sw_out_pkg::DEF_EXT;
            n.alarm_low = sw_out_pkg::DEF_ALARM_LOW;
            n.ds_lock = sw_out_pkg::DEF_DS_LOCK;
        end else if (param_wr) begin
            // Undefined codes leave the old setting in place
            if (wr_mode != 2'h3) begin
                n.mode = sw_out_pkg::sp_mode_t'(wr_mode);
            end
            if (wr_ext <= 3'(sw_out_pkg::EXT_1S)) begin
                n.ext = sw_out_pkg::ext_sel_t'(wr_ext);
            end
            n.nc = wr_nc;
            n.alarm_low = wr_alarm_low;
            n.ds_lock = wr_ds_lock;
        end

        // New change wins over an acknowledge in the same cycle
        n.ds_pend = (q.ds_pend & ~ds_ack) |
            (!n.ds_lock && (n.mode != q.mode || n.nc != q.nc ||
             n.ext != q.ext || n.alarm_low != q.alarm_low ||
             n.ds_lock != q.ds_lock));
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= RST_STATE;
        end else if (ce) begin
            q <= n;
        end
    end

    assign ds_upload_req = q.ds_pend;
    assign switch_out = q.pd[sw_out_pkg::PD_SWITCH_BIT];
    assign led_flash = q.blink;
    assign pd_in = q.pd;
    assign switch_status = q.det;
    assign diag_status = q.alarm;
    assign temp_state = q.temp;
    assign min_cycle_us = sw_out_pkg::MIN_CYCLE_US;
    assign master_cycle_time = q.mcyc;
    assign version_id = sw_out_pkg::VERSION_ID;
    assign cur_mode = q.mode;
    assign cur_nc = q.nc;
    assign cur_ext = q.ext;
    assign cur_alarm_low = q.alarm_low;
    assign cur_ds_lock = q.ds_lock;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence restore_s;
        ce && factory_restore;
    endsequence

    sequence locked_write_s;
        ce && param_wr && !factory_restore && wr_ds_lock && !q.ds_pend;
    endsequence

    direct_output_a: assert property (
        ce && !ext_on |=> switch_out == $past(det_raw ^ q.nc))
        else $error("Switching output not following detection");

    switch_status_a: assert property (
        ce |=> switch_status == $past(det_raw))
        else $error("Switching status differs from detection");

    pd_layout_a: assert property (
        pd_in[sw_out_pkg::PD_W-1:2] == '0 && pd_in[0] == switch_out)
        else $error("Process data layout broken");

    alarm_polarity_a: assert property (
        ce |=> pd_in[1] == (diag_status ^ $past(cur_alarm_low)))
        else $error("Diagnosis bit polarity wrong");

    near_no_alarm_a: assert property (
        ce && q.mode == sw_out_pkg::MODE_NEAR |=> !diag_status)
        else $error("Alarm raised in near setpoint mode");

    rated_alarm_a: assert property (
        ce && q.mode == sw_out_pkg::MODE_RATED &&
        q.pins[sw_out_pkg::PIN_RATED] && !q.pins[sw_out_pkg::PIN_ASSURED]
        |=> diag_status)
        else $error("Marginal zone alarm missing");

    window_alarm_a: assert property (
        ce && q.mode == sw_out_pkg::MODE_WINDOW &&
        q.pins[sw_out_pkg::PIN_NEAR] |=> diag_status)
        else $error("Below window alarm missing");

    restore_defaults_a: assert property (
        restore_s |=> cur_mode == sw_out_pkg::DEF_MODE &&
        cur_ext == sw_out_pkg::DEF_EXT && cur_nc == sw_out_pkg::DEF_NC &&
        cur_ds_lock == sw_out_pkg::DEF_DS_LOCK)
        else $error("Factory restore left a parameter changed");

    storage_lock_a: assert property (
        locked_write_s |=> !ds_upload_req)
        else $error("Change forwarded while storage is locked");

    temp_over_a: assert property (
        ce && q.pins[sw_out_pkg::PIN_TEMP_OVER] |=>
        temp_state == sw_out_pkg::TEMP_OVER)
        else $error("Overtemperature not reported");

    led_idle_a: assert property (
        ce && !q.alarm |=> !led_flash)
        else $error("LED flashing without alarm");

    freeze_state_a: assert property (
        !ce |=> q == $past(q))
        else $error("State moved while clock enable low");

    master_cycle_a: assert property (
        ce && master_cycle_wr |=> master_cycle_time == $past(master_cycle_us))
        else $error("Master cycle time not latched");

    ack_clear_a: assert property (
        ce && ds_ack && !param_wr && !factory_restore |=> !ds_upload_req)
        else $error("Upload request not cleared by acknowledge");

    sequence blink_due_s;
        ce && q.alarm && q.blink_cnt >= BLINK_CYC - sw_out_pkg::TMR_W'(1);
    endsequence

    blink_toggle_a: assert property (
        blink_due_s |=> led_flash != $past(led_flash))
        else $error("LED did not toggle while alarm stands");

    window_detect_a: assert property (
        ce && q.mode == sw_out_pkg::MODE_WINDOW |=> switch_status ==
        $past(q.pins[sw_out_pkg::PIN_RATED] && !q.pins[sw_out_pkg::PIN_NEAR]))
        else $error("Window detection wrong");

endmodule

// ### test/link_master_model.sv
`timescale 1ns/1ps
module link_master_model (
    // Clock and upload handshake
    input wire logic sys_clk,
    input wire logic ds_upload_req,
    output logic ds_ack,
    // Parameter set seen in the device: mode, nc, ext, alarm_low, lock
    input wire logic [7:0] cur_set,
    // Parameter and cycle writes
    output logic param_wr,
    output logic [1:0] wr_mode,
    output logic wr_nc,
    output logic [2:0] wr_ext,
    output logic wr_alarm_low,
    output logic wr_ds_lock,
    output logic factory_restore,
    output logic master_cycle_wr,
    output logic [15:0] master_cycle_us
);
    int ack_wait = 4;
    logic [7:0] stored = 8'h00;

    initial begin
        ds_ack = 1'b0;
        param_wr = 1'b0;
        {wr_mode, wr_nc, wr_ext, wr_alarm_low, wr_ds_lock} = 8'h00;
        factory_restore = 1'b0;
        master_cycle_wr = 1'b0;
        master_cycle_us = 16'h0000;
    end

    // Fields flip once the strobe drops, so stale data is never reused
    task automatic write_params(input logic [7:0] s);
        param_wr = 1'b1;
        {wr_mode, wr_nc, wr_ext, wr_alarm_low, wr_ds_lock} = s;
        @(negedge sys_clk);
        param_wr = 1'b0;
        {wr_mode, wr_nc, wr_ext, wr_alarm_low, wr_ds_lock} = ~s;
    endtask

    task automatic write_cycle(input logic [15:0] us);
        master_cycle_wr = 1'b1;
        master_cycle_us = us;
        @(negedge sys_clk);
        master_cycle_wr = 1'b0;
        master_cycle_us = ~us;
    endtask

    task automatic restore_cmd();
        factory_restore = 1'b1;
        @(negedge sys_clk);
        factory_restore = 1'b0;
    endtask

    // Replacement or power cycle: push the stored set back
    task automatic rewrite_stored();
        write_params(stored);
    endtask

    // Slow on purpose, so the pending flag can be observed first
    always begin
        @(negedge sys_clk);
        if (ds_upload_req === 1'b1) begin
            repeat (ack_wait) @(negedge sys_clk);
            stored = cur_set;
            ds_ack = 1'b1;
            @(negedge sys_clk);
            ds_ack = 1'b0;
        end
    end
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
    logic sys_clk;
    logic rst;
    logic ce;
    logic near_hit;
    logic rated_hit;
    logic assured_hit;
    logic temp_high;
    logic temp_over;
    logic param_wr, wr_nc, wr_alarm_low, wr_ds_lock, factory_restore;
    logic [1:0] wr_mode, temp_state, cur_mode;
    logic [2:0] wr_ext, cur_ext;
    logic master_cycle_wr, ds_ack, ds_upload_req, switch_out, led_flash;
    logic [15:0] master_cycle_us, min_cycle_us, master_cycle_time;
    logic [7:0] pd_in, version_id;
    logic switch_status, diag_status, cur_nc, cur_alarm_low, cur_ds_lock;
    logic [7:0] cur_set;
    int miscompares = 0;
    int samples_checked = 0;
    logic [2:0] pins [4] = '{3'b010, 3'b111, 3'b011, 3'b000};

    assign cur_set = {cur_mode, cur_nc, cur_ext, cur_alarm_low, cur_ds_lock};

    always #10 sys_clk = ~sys_clk;

    switching_output_conditioner #(.CYC_10MS(26'h14), .CYC_100MS(26'h28),
        .CYC_1S(26'h50), .BLINK_CYC(26'h8)) i_switching_output_conditioner (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .near_hit(near_hit),
        .rated_hit(rated_hit), .assured_hit(assured_hit),
        .temp_high(temp_high), .temp_over(temp_over), .param_wr(param_wr),
        .wr_mode(wr_mode), .wr_nc(wr_nc), .wr_ext(wr_ext),
        .wr_alarm_low(wr_alarm_low), .wr_ds_lock(wr_ds_lock),
        .factory_restore(factory_restore), .master_cycle_wr(master_cycle_wr),
        .master_cycle_us(master_cycle_us), .ds_ack(ds_ack),
        .ds_upload_req(ds_upload_req), .switch_out(switch_out),
        .led_flash(led_flash), .pd_in(pd_in), .switch_status(switch_status),
        .diag_status(diag_status), .temp_state(temp_state),
        .min_cycle_us(min_cycle_us), .master_cycle_time(master_cycle_time),
        .version_id(version_id), .cur_mode(cur_mode), .cur_nc(cur_nc),
        .cur_ext(cur_ext), .cur_alarm_low(cur_alarm_low),
        .cur_ds_lock(cur_ds_lock));

    link_master_model i_master (
        .sys_clk(sys_clk), .ds_upload_req(ds_upload_req), .ds_ack(ds_ack),
        .cur_set(cur_set), .param_wr(param_wr), .wr_mode(wr_mode),
        .wr_nc(wr_nc), .wr_ext(wr_ext), .wr_alarm_low(wr_alarm_low),
        .wr_ds_lock(wr_ds_lock), .factory_restore(factory_restore),
        .master_cycle_wr(master_cycle_wr), .master_cycle_us(master_cycle_us));

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked,
            miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic hang();
        miscompares++;
        report_and_stop();
    endtask

    // Five edges through the input filter, one spare
    task automatic set_pins(input logic [2:0] p);
        {near_hit, rated_hit, assured_hit} = p;
        repeat (6) @(negedge sys_clk);
    endtask

    // Returns {alarm, detection} with no polarity applied
    function automatic logic [1:0] expect_fn(input logic [1:0] m,
        input logic [2:0] p);
        case (m)
            2'h0: return {p[1] & ~p[0], p[1]};
            2'h1: return {1'b0, p[2]};
            default: return {p[2], p[1] & ~p[2]};
        endcase
    endfunction

    task automatic reset_case();
        chk(min_cycle_us, 16'h08fc);
        chk(version_id, 8'h11);
        chk(master_cycle_time, 16'h0000);
        chk(cur_set, 8'h00);
        chk(pd_in, 8'h00);
    endtask

    task automatic temp_case();
        temp_high = 1'b1;
        set_pins(3'b000);
        chk(temp_state, 2'h1);
        temp_over = 1'b1;
        set_pins(3'b000);
        chk(temp_state, 2'h2);
        {temp_high, temp_over} = 2'b00;
        set_pins(3'b000);
        chk(temp_state, 2'h0);
    endtask

    // Pins and a write while the clock enable is low must change nothing
    task automatic freeze_case();
        ce = 1'b0;
        set_pins(3'b111);
        i_master.write_params(8'b10_1_010_1_0);
        chk(pd_in, 8'h00);
        chk(switch_status, 1'b0);
        chk(cur_set, 8'h00);
        ce = 1'b1;
        set_pins(3'b111);
        chk(pd_in, 8'h01);
        chk(switch_status, 1'b1);
        set_pins(3'b000);
    endtask

    task automatic mode_case();
        logic [1:0] e;
        logic l;
        int t;
        for (int m = 0; m < 3; m++) begin
            for (int al = 0; al < 2; al++) begin
                for (int p = 0; p < 4; p++) begin
                    i_master.write_params({m[1:0], 4'h0, al[0], 1'b0});
                    set_pins(pins[p]);
                    e = expect_fn(m[1:0], pins[p]);
                    chk(pd_in, {6'h00, e[1] ^ al[0], e[0]});
                    chk(switch_status, e[0]);
                    chk(diag_status, e[1]);
                    chk(switch_out, e[0]);
                    if (e[1]) begin
                        l = led_flash;
                        t = 0;
                        while (led_flash === l && t < 20) begin
                            @(negedge sys_clk);
                            t++;
                        end
                        if (t == 20) begin
                            hang();
                        end
                    end else begin
                        chk(led_flash, 1'b0);
                    end
                end
            end
        end
    endtask

    // Counts high samples of the channel bit around one or two pulses
    task automatic stretch_case(input logic [2:0] ext, input int dur,
        input logic nc, input logic tw);
        int cnt;
        int lo;
        cnt = 0;
        lo = tw ? dur + 10 : dur - 1;
        i_master.write_params({2'h0, nc, ext, 2'b00});
        rated_hit = nc;
        repeat (dur + 20) @(negedge sys_clk);
        for (int i = 0; i < dur + 40; i++) begin
            rated_hit = nc ^ (i < 3 || (tw && i >= 11 && i < 14));
            @(negedge sys_clk);
            if (pd_in[0] === 1'b1) begin
                cnt++;
            end
        end
        chk(cnt >= lo && cnt <= lo + 3, 1'b1);
    endtask

    task automatic wait_req_clear();
        int t;
        t = 0;
        while (ds_upload_req !== 1'b0 && t < 20) begin
            @(negedge sys_clk);
            t++;
        end
        if (t == 20) begin
            hang();
        end
    endtask

    task automatic storage_case();
        i_master.write_params(8'b10_0_010_1_0);
        chk(ds_upload_req, 1'b1);
        wait_req_clear();
        i_master.write_params(8'b11_0_111_1_0);
        chk(cur_set, 8'b10_0_010_1_0);
        @(negedge sys_clk);
        i_master.write_params(8'b01_1_011_0_1);
        repeat (6) @(negedge sys_clk);
        chk(ds_upload_req, 1'b0);
        chk(cur_set, 8'b01_1_011_0_1);
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        chk(cur_set, 8'h00);
        i_master.rewrite_stored();
        chk(cur_set, 8'b10_0_010_1_0);
        wait_req_clear();
        i_master.restore_cmd();
        chk(cur_set, 8'h00);
        wait_req_clear();
    endtask

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        {near_hit, rated_hit, assured_hit, temp_high, temp_over} = 5'h00;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        reset_case();
        temp_case();
        freeze_case();
        mode_case();
        stretch_case(3'h0, 3, 1'b0, 1'b0);
        stretch_case(3'h2, 20, 1'b0, 1'b0);
        stretch_case(3'h3, 40, 1'b0, 1'b1);
        stretch_case(3'h4, 80, 1'b1, 1'b0);
        i_master.write_cycle(16'h0001);
        chk(master_cycle_time, 16'h0001);
        stretch_case(3'h1, 50, 1'b0, 1'b0);
        storage_case();
        report_and_stop();
    end
endmodule
